// ==== dv/temp_monitor_register_bank_tb_top.sv ====
`timescale 1ns/100ps
module temp_monitor_register_bank_tb_top;
  import tmrb_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               done = 1'b0;
  logic signed [11:0] loc = '0;
  logic signed [11:0] rem = '0;
  tmrb_bus_req_t      req;
  tmrb_conv_t         conv;
  logic [7:0]         rdata;
  logic               rvalid, start, busy, cut_n, shr_n;
  int                 fail_count = 0, num_checks = 0, conv_count = 0, start_count = 0;
  int                 cyc = 0, last_st = 0, prev_st = 0;
  assign conv = '{local_deg: loc, remote_qtr: rem};
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tmrb_regbank #(.BASE_TICK_CYCLES(8)) uut (.CLK_I(clk), .SYS_RST_I(rst), .BUS_REQ_I(req),
    .CONV_DONE_I(done), .CONV_RESULT_I(conv), .BUS_RDATA_O(rdata), .BUS_RVALID_O(rvalid),
    .CONV_START_O(start), .CONV_BUSY_O(busy), .OVERTEMP_CUTOFF_OUT_N_O(cut_n),
    .SHARED_PIN_N_O(shr_n));
  tmrb_host_model host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  // Converter answers each start after three cycles
  always begin
    @(posedge clk);
    if (start === 1'b1) begin
      prev_st = last_st;
      last_st = cyc;
      start_count++;
      repeat (3) @(negedge clk);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      conv_count++;
    end
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.wr(a, 8'h00, 1'b0);
    host.rd(d, v);
    chk(n, 8'(v), 8'h01);
    chk(n, d, e);
  endtask
  task automatic cfg(input logic [7:0] d);
    host.wr(ADDR_CONFIG_WR, d, 1'b1);
    repeat (4) @(negedge clk);
  endtask
  task automatic wait_conv;
    int c;
    c = conv_count;
    for (int i = 0; i < 600 && conv_count < c + 2; i++) @(negedge clk);
    chk("conv wait", 8'(conv_count >= c + 2), 8'h01);
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    logic       v;
    host.rd(d, v);
    chk("first read", d, RST_RESULT);
    rd_chk("remote hi", ADDR_REMOTE_RESULT_HI, 8'h00);
    rd_chk("remote lo", ADDR_REMOTE_RESULT_LO, 8'h00);
    rd_chk("config", ADDR_CONFIG_RD, 8'h00);
    rd_chk("rate", ADDR_RATE_RD, 8'h08);
    rd_chk("hyst", ADDR_CUTOFF_HYST, 8'h0A);
    $display("test reset finished");
  endtask
  task automatic t_regs;
    host.wr(ADDR_LOCAL_RESULT, 8'h5A, 1'b1);
    host.wr(8'h02, 8'h5A, 1'b1);
    host.wr(ADDR_LOCAL_HIGH_RD, 8'h5A, 1'b1);
    rd_chk("local ro", ADDR_LOCAL_RESULT, 8'h00);
    rd_chk("high lim", ADDR_LOCAL_HIGH_RD, 8'h55);
    host.wr(ADDR_REMOTE_LOW_HI_WR, 8'h0A, 1'b1);
    rd_chk("rem low hi", ADDR_REMOTE_LOW_HI_RD, 8'h0A);
    host.wr(ADDR_REMOTE_HIGH_LO, 8'hC0, 1'b1);
    rd_chk("rem high lo", ADDR_REMOTE_HIGH_LO, 8'hC0);
    host.wr(ADDR_REMOTE_LOW_HI_WR, 8'h00, 1'b1);
    cfg(8'hA4);
    rd_chk("config wr", ADDR_CONFIG_RD, 8'hA4);
    host.wr(ADDR_RATE_WR, 8'h0A, 1'b1);
    rd_chk("rate wr", ADDR_RATE_RD, 8'h0A);
    host.wr(ADDR_RATE_WR, 8'h08, 1'b1);
    cfg(8'h00);
    $display("test registers finished");
  endtask
  task automatic t_conv;
    loc = 12'sd50;
    rem = 12'sd201;
    wait_conv();
    rd_chk("local", ADDR_LOCAL_RESULT, 8'h32);
    rd_chk("remote hi", ADDR_REMOTE_RESULT_HI, 8'h32);
    rd_chk("remote lo", ADDR_REMOTE_RESULT_LO, 8'h40);
    cfg(8'h04);
    wait_conv();
    rd_chk("ext local", ADDR_LOCAL_RESULT, 8'h72);
    rd_chk("ext remote", ADDR_REMOTE_RESULT_HI, 8'h72);
    rd_chk("limit kept", ADDR_LOCAL_HIGH_RD, 8'h55);
    cfg(8'h00);
    wait_conv();
    rd_chk("back binary", ADDR_LOCAL_RESULT, 8'h32);
    $display("test conversion finished");
  endtask
  task automatic t_alarm;
    loc = 12'sd90;
    wait_conv();
    chk("alarm high", 8'(shr_n), 8'h00);
    chk("cutoff", 8'(cut_n), 8'h00);
    cfg(8'h80);
    chk("alarm mask", 8'(shr_n), 8'h01);
    cfg(8'hA0);
    chk("second cutoff", 8'(shr_n), 8'h00);
    loc = 12'sd80;
    wait_conv();
    chk("cutoff hold", 8'(cut_n), 8'h00);
    chk("second hold", 8'(shr_n), 8'h00);
    loc = 12'sd70;
    wait_conv();
    chk("cutoff free", 8'(cut_n), 8'h01);
    chk("second free", 8'(shr_n), 8'h01);
    cfg(8'h00);
    loc = 12'sd0;
    wait_conv();
    chk("alarm low", 8'(shr_n), 8'h00);
    loc = 12'sd50;
    wait_conv();
    chk("alarm clear", 8'(shr_n), 8'h01);
    $display("test alarm finished");
  endtask
  task automatic t_standby;
    int c;
    cfg(8'h40);
    repeat (40) @(negedge clk);
    c = start_count;
    repeat (100) @(negedge clk);
    chk("halted", 8'(start_count - c), 8'h00);
    chk("busy idle", 8'(busy), 8'h00);
    rd_chk("bus alive", ADDR_CONFIG_RD, 8'h40);
    host.wr(ADDR_LOCAL_CUTOFF, 8'h28, 1'b1);
    repeat (4) @(negedge clk);
    chk("standby trip", 8'(cut_n), 8'h00);
    host.wr(ADDR_LOCAL_CUTOFF, 8'h55, 1'b1);
    repeat (4) @(negedge clk);
    chk("standby free", 8'(cut_n), 8'h01);
    cfg(8'h00);
    $display("test standby finished");
  endtask
  task automatic measure(input logic [7:0] code, output int s);
    int c;
    host.wr(ADDR_RATE_WR, code, 1'b1);
    c = start_count;
    for (int i = 0; i < 2000 && start_count < c + 3; i++) @(negedge clk);
    chk("rate starts", 8'(start_count >= c + 3), 8'h01);
    s = last_st - prev_st;
  endtask
  task automatic t_rate;
    int s1, s2, s3;
    measure(8'h0A, s1);
    measure(8'h09, s2);
    measure(8'h0B, s3);
    chk("slower code", 8'(s2 > s1), 8'h01);
    chk("reserved code", 8'(s3), 8'(s1));
    host.wr(ADDR_RATE_WR, 8'h08, 1'b1);
    $display("test rate finished");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_conv();
    t_alarm();
    t_standby();
    t_rate();
    stop_test();
  end
endmodule

// ==== dv/tmrb_host_model.sv ====
`timescale 1ns/100ps
module tmrb_host_model (
  input  wire logic              clk_i,
  input  wire logic [7:0]        rdata_i,
  input  wire logic              rvalid_i,
  output tmrb_pkg::tmrb_bus_req_t req_o
);
  import tmrb_pkg::*;
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit with_data);
    logic [7:0] v;
    v = d;
    if (a == ADDR_RATE_WR) v = d & RATE_USED_MASK;
    if (a == ADDR_CONFIG_WR) v = d & CFG_USED_MASK;
    @(negedge clk_i);
    req_o = '{wr_byte: 1'b1, wr_first: 1'b1, rd_byte: 1'b0, wdata: a};
    if (with_data) begin
      @(negedge clk_i);
      req_o = '{wr_byte: 1'b1, wr_first: 1'b0, rd_byte: 1'b0, wdata: v};
    end
    @(negedge clk_i);
    req_o = '{wr_byte: 1'b0, wr_first: 1'b0, rd_byte: 1'b0, wdata: ~v};
  endtask
  task automatic rd(output logic [7:0] d, output logic ok);
    @(negedge clk_i);
    req_o.rd_byte = 1'b1;
    @(negedge clk_i);
    req_o.rd_byte = 1'b0;
    d  = rdata_i;
    ok = rvalid_i;
  endtask
endmodule

// ==== dv/tmrb_regbank_monitor.sv ====
`timescale 1ns/100ps
module tmrb_regbank_monitor #(
  parameter int BASE_TICK_CYCLES = 8
) (
  input wire logic                   CLK_I,
  input wire logic                   SYS_RST_I,
  input wire tmrb_pkg::tmrb_bus_req_t BUS_REQ_I,
  input wire logic                   CONV_DONE_I,
  input wire tmrb_pkg::tmrb_conv_t   CONV_RESULT_I,
  input wire logic [7:0]             BUS_RDATA_O,
  input wire logic                   BUS_RVALID_O,
  input wire logic                   CONV_START_O,
  input wire logic                   CONV_BUSY_O,
  input wire logic                   OVERTEMP_CUTOFF_OUT_N_O,
  input wire logic                   SHARED_PIN_N_O
);
  import tmrb_pkg::*;
  logic [7:0] ptr_r;
  logic [7:0] cfg_r;
  logic [7:0] rate_r;
  logic       armed_r;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Shadow pointer and pairing
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ptr_r   <= RST_POINTER;
      armed_r <= 1'b0;
    end else if (BUS_REQ_I.wr_byte) begin
      if (BUS_REQ_I.wr_first) ptr_r <= BUS_REQ_I.wdata;
      armed_r <= BUS_REQ_I.wr_first;
    end
  end
  // Shadow config and rate
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cfg_r  <= RST_CONFIG;
      rate_r <= RST_RATE;
    end else if (BUS_REQ_I.wr_byte && !BUS_REQ_I.wr_first && armed_r) begin
      if (ptr_r == ADDR_CONFIG_WR) cfg_r <= BUS_REQ_I.wdata & CFG_USED_MASK;
      if (ptr_r == ADDR_RATE_WR) rate_r <= BUS_REQ_I.wdata;
    end
  end
  AST_RD_ANSWER: assert property (BUS_REQ_I.rd_byte |=> BUS_RVALID_O)
    else $error("read answer missing");
  AST_RVALID_CAUSE: assert property (BUS_RVALID_O |-> $past(BUS_REQ_I.rd_byte))
    else $error("read answer without request");
  AST_RDATA_HOLD: assert property (!BUS_RVALID_O |-> $stable(BUS_RDATA_O))
    else $error("read data changed without read");
  AST_CFG_READ: assert property (BUS_REQ_I.rd_byte && ptr_r == ADDR_CONFIG_RD
    |=> BUS_RDATA_O == $past(cfg_r)) else $error("config readback wrong");
  AST_RATE_READ: assert property (BUS_REQ_I.rd_byte && ptr_r == ADDR_RATE_RD
    |=> BUS_RDATA_O == $past(rate_r)) else $error("rate readback wrong");
  AST_START_PULSE: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("start longer than one cycle");
  AST_START_BUSY: assert property (CONV_START_O |-> CONV_BUSY_O)
    else $error("start without busy");
  AST_DONE_IDLE: assert property (CONV_BUSY_O && CONV_DONE_I |-> ##[1:2] !CONV_BUSY_O)
    else $error("busy stuck after done");
  AST_STANDBY_HALT: assert property (cfg_r[CFG_STANDBY_BIT]
    && $past(cfg_r[CFG_STANDBY_BIT], 2) |-> !CONV_START_O) else $error("start in standby");
  COV_START: cover property (CONV_START_O);
  COV_CUTOFF: cover property (!OVERTEMP_CUTOFF_OUT_N_O);
  COV_CFG_RD: cover property (BUS_RVALID_O && ptr_r == ADDR_CONFIG_RD);
endmodule
bind tmrb_regbank tmrb_regbank_monitor #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) u_mon (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .BUS_REQ_I(BUS_REQ_I), .CONV_DONE_I(CONV_DONE_I),
  .CONV_RESULT_I(CONV_RESULT_I), .BUS_RDATA_O(BUS_RDATA_O), .BUS_RVALID_O(BUS_RVALID_O),
  .CONV_START_O(CONV_START_O), .CONV_BUSY_O(CONV_BUSY_O),
  .OVERTEMP_CUTOFF_OUT_N_O(OVERTEMP_CUTOFF_OUT_N_O), .SHARED_PIN_N_O(SHARED_PIN_N_O));

// ==== logic/tmrb_pkg.sv ====
package tmrb_pkg;

  // Register addresses, read side
  localparam logic [7:0] ADDR_LOCAL_RESULT     = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_RESULT_HI = 8'h01;
  localparam logic [7:0] ADDR_CONFIG_RD        = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD          = 8'h04;
  localparam logic [7:0] ADDR_LOCAL_HIGH_RD    = 8'h05;
  localparam logic [7:0] ADDR_LOCAL_LOW_RD     = 8'h06;
  localparam logic [7:0] ADDR_REMOTE_HIGH_HI_RD = 8'h07;
  localparam logic [7:0] ADDR_REMOTE_LOW_HI_RD = 8'h08;
  localparam logic [7:0] ADDR_REMOTE_RESULT_LO = 8'h10;
  // Register addresses, write side
  localparam logic [7:0] ADDR_CONFIG_WR        = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR          = 8'h0A;
  localparam logic [7:0] ADDR_LOCAL_HIGH_WR    = 8'h0B;
  localparam logic [7:0] ADDR_LOCAL_LOW_WR     = 8'h0C;
  localparam logic [7:0] ADDR_REMOTE_HIGH_HI_WR = 8'h0D;
  localparam logic [7:0] ADDR_REMOTE_LOW_HI_WR = 8'h0E;
  // Same address for read and write
  localparam logic [7:0] ADDR_REMOTE_HIGH_LO   = 8'h13;
  localparam logic [7:0] ADDR_REMOTE_LOW_LO    = 8'h14;
  localparam logic [7:0] ADDR_REMOTE_CUTOFF    = 8'h19;
  localparam logic [7:0] ADDR_LOCAL_CUTOFF     = 8'h20;
  localparam logic [7:0] ADDR_CUTOFF_HYST      = 8'h21;

  // Reset values
  localparam logic [7:0] RST_POINTER      = 8'h00;
  localparam logic [7:0] RST_RESULT       = 8'h00;
  localparam logic [7:0] RST_CONFIG       = 8'h00;
  localparam logic [7:0] RST_RATE         = 8'h08;
  localparam logic [7:0] RST_HIGH_LIMIT   = 8'h55;
  localparam logic [7:0] RST_LOW_LIMIT    = 8'h00;
  localparam logic [7:0] RST_LIMIT_LO     = 8'h00;
  localparam logic [7:0] RST_CUTOFF_LIMIT = 8'h55;
  localparam logic [7:0] RST_HYST         = 8'h0A;

  // Configuration fields
  localparam int          CFG_ALARM_MASK_BIT     = 7;
  localparam int          CFG_STANDBY_BIT        = 6;
  localparam int          CFG_SHARED_PIN_FUNCTION_BIT = 5;
  localparam int          CFG_RANGE_BIT          = 2;
  localparam logic [7:0]  CFG_USED_MASK          = 8'hE4;
  localparam logic [7:0]  RATE_USED_MASK         = 8'h0F;
  localparam logic [3:0]  RATE_CODE_FASTEST      = 4'hA;
  localparam logic [7:0]  REMOTE_LO_USED_MASK    = 8'hC0;

  // Result encoding
  localparam logic signed [11:0] EXT_OFFSET_DEG  = 12'sh040;
  localparam logic signed [11:0] EXT_OFFSET_QTR  = 12'sh100;
  localparam logic signed [11:0] BIN_MAX_DEG     = 12'sh07F;
  localparam logic signed [11:0] EXT_MAX_DEG     = 12'sh0FF;
  localparam logic signed [11:0] BIN_MAX_QTR     = 12'sh1FF;
  localparam logic signed [11:0] EXT_MAX_QTR     = 12'sh3FF;

  // Timing
  localparam int BASE_PERIOD_NS = 15_500_000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BASE_TICK_CYCLES_DFLT = BASE_PERIOD_NS / CLK_PERIOD_NS;

  // Converter hand-off: local in whole degrees, remote in quarter degrees
  typedef struct packed {
    logic signed [11:0] local_deg;
    logic signed [11:0] remote_qtr;
  } tmrb_conv_t;

  // Byte-level serial bus request
  typedef struct packed {
    logic       wr_byte;
    logic       wr_first;
    logic       rd_byte;
    logic [7:0] wdata;
  } tmrb_bus_req_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_WAIT    = 2'b01,
    ST_CONVERT = 2'b11
  } tmrb_state_t;

endpackage

// ==== logic/tmrb_regbank.sv ====
`timescale 1ns/100ps
module tmrb_regbank #(
  parameter int BASE_TICK_CYCLES = tmrb_pkg::BASE_TICK_CYCLES_DFLT
) (
  input  wire logic                   CLK_I,
  input  wire logic                   SYS_RST_I,
  input  wire tmrb_pkg::tmrb_bus_req_t BUS_REQ_I,
  input  wire logic                   CONV_DONE_I,
  input  wire tmrb_pkg::tmrb_conv_t   CONV_RESULT_I,
  output logic [7:0]                  BUS_RDATA_O,
  output logic                        BUS_RVALID_O,
  output logic                        CONV_START_O,
  output logic                        CONV_BUSY_O,
  output logic                        OVERTEMP_CUTOFF_OUT_N_O,
  output logic                        SHARED_PIN_N_O
);
  import tmrb_pkg::*;

  logic [7:0]  pointer_r;
  logic        data_phase_r;
  logic [7:0]  local_res_r;
  logic [7:0]  remote_hi_r;
  logic [7:0]  remote_lo_r;
  logic [7:0]  config_r;
  logic [7:0]  rate_r;
  logic [7:0]  local_high_r;
  logic [7:0]  local_low_r;
  logic [7:0]  remote_high_hi_r;
  logic [7:0]  remote_high_lo_r;
  logic [7:0]  remote_low_hi_r;
  logic [7:0]  remote_low_lo_r;
  logic [7:0]  local_cut_r;
  logic [7:0]  remote_cut_r;
  logic [7:0]  hyst_r;
  logic        range_conv_r;
  tmrb_state_t state_r;
  tmrb_state_t state_nxt;
  logic [31:0] base_cnt_r;
  logic [10:0] div_cnt_r;
  logic        base_tick;
  logic        interval_due;
  logic        reg_wr;
  logic [3:0]  rate_code;
  logic [10:0] div_last;
  logic [7:0]  rdata_nxt;
  logic [7:0]  local_enc;
  logic [9:0]  remote_enc;
  logic [9:0]  remote_val;
  logic [9:0]  remote_high;
  logic [9:0]  remote_low;
  logic        standby;
  logic        pin_is_cutoff;

  localparam int NUM_CH = 2;
  logic [NUM_CH-1:0] cut_vec;
  logic [NUM_CH-1:0] cut2_vec;
  logic [NUM_CH-1:0] alarm_vec;

  // Saturate to the range limits
  function automatic logic signed [11:0] clamp(input logic signed [11:0] v,
                                               input logic signed [11:0] hi);
    if (v < 12'sh000) begin
      clamp = 12'sh000;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  // Release threshold, floored at zero
  function automatic logic [8:0] release_at(input logic [7:0] lim, input logic [7:0] hy);
    if (lim >= hy) begin
      release_at = {1'b0, lim} - {1'b0, hy};
    end else begin
      release_at = 9'h000;
    end
  endfunction

  assign standby       = config_r[CFG_STANDBY_BIT];
  assign pin_is_cutoff = config_r[CFG_SHARED_PIN_FUNCTION_BIT];
  assign reg_wr        = BUS_REQ_I.wr_byte && !BUS_REQ_I.wr_first && data_phase_r;

  // Pointer load on first byte
  // pointer capture
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pointer_r    <= RST_POINTER;
      data_phase_r <= 1'b0;
    end else if (BUS_REQ_I.wr_byte) begin
      if (BUS_REQ_I.wr_first) begin
        pointer_r    <= BUS_REQ_I.wdata;
        data_phase_r <= 1'b1;
      end else begin
        // Further data bytes are ignored
        data_phase_r <= 1'b0;
      end
    end
  end

  // Writable registers; writes elsewhere are dropped
  // second byte store
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      config_r         <= RST_CONFIG;
      rate_r           <= RST_RATE;
      local_high_r     <= RST_HIGH_LIMIT;
      local_low_r      <= RST_LOW_LIMIT;
      remote_high_hi_r <= RST_HIGH_LIMIT;
      remote_high_lo_r <= RST_LIMIT_LO;
      remote_low_hi_r  <= RST_LOW_LIMIT;
      remote_low_lo_r  <= RST_LIMIT_LO;
      local_cut_r      <= RST_CUTOFF_LIMIT;
      remote_cut_r     <= RST_CUTOFF_LIMIT;
      hyst_r           <= RST_HYST;
    end else if (reg_wr) begin
      case (pointer_r)
        // Reserved config and remote low-byte bits read back as zero; rate keeps all written bits
        // used bits only
        ADDR_CONFIG_WR:         config_r         <= BUS_REQ_I.wdata & CFG_USED_MASK;
        ADDR_RATE_WR:           rate_r           <= BUS_REQ_I.wdata;
        ADDR_LOCAL_HIGH_WR:     local_high_r     <= BUS_REQ_I.wdata;
        ADDR_LOCAL_LOW_WR:      local_low_r      <= BUS_REQ_I.wdata;
        ADDR_REMOTE_HIGH_HI_WR: remote_high_hi_r <= BUS_REQ_I.wdata;
        ADDR_REMOTE_LOW_HI_WR:  remote_low_hi_r  <= BUS_REQ_I.wdata;
        ADDR_REMOTE_HIGH_LO:    remote_high_lo_r <= BUS_REQ_I.wdata & REMOTE_LO_USED_MASK;
        ADDR_REMOTE_LOW_LO:     remote_low_lo_r  <= BUS_REQ_I.wdata & REMOTE_LO_USED_MASK;
        ADDR_REMOTE_CUTOFF:     remote_cut_r     <= BUS_REQ_I.wdata;
        ADDR_LOCAL_CUTOFF:      local_cut_r      <= BUS_REQ_I.wdata;
        ADDR_CUTOFF_HYST:       hyst_r           <= BUS_REQ_I.wdata;
        default: ;
      endcase
    end
  end

  // Read mux from the pointer
  always_comb begin
    case (pointer_r)
      ADDR_LOCAL_RESULT:      rdata_nxt = local_res_r;
      ADDR_REMOTE_RESULT_HI:  rdata_nxt = remote_hi_r;
      ADDR_REMOTE_RESULT_LO:  rdata_nxt = remote_lo_r;
      ADDR_CONFIG_RD:         rdata_nxt = config_r;
      ADDR_RATE_RD:           rdata_nxt = rate_r;
      ADDR_LOCAL_HIGH_RD:     rdata_nxt = local_high_r;
      ADDR_LOCAL_LOW_RD:      rdata_nxt = local_low_r;
      ADDR_REMOTE_HIGH_HI_RD: rdata_nxt = remote_high_hi_r;
      ADDR_REMOTE_LOW_HI_RD:  rdata_nxt = remote_low_hi_r;
      ADDR_REMOTE_HIGH_LO:    rdata_nxt = remote_high_lo_r;
      ADDR_REMOTE_LOW_LO:     rdata_nxt = remote_low_lo_r;
      ADDR_REMOTE_CUTOFF:     rdata_nxt = remote_cut_r;
      ADDR_LOCAL_CUTOFF:      rdata_nxt = local_cut_r;
      ADDR_CUTOFF_HYST:       rdata_nxt = hyst_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  // Read data holds until the next read
  // read from pointed register
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      BUS_RDATA_O  <= 8'h00;
      BUS_RVALID_O <= 1'b0;
    end else begin
      BUS_RVALID_O <= BUS_REQ_I.rd_byte;
      if (BUS_REQ_I.rd_byte) begin
        BUS_RDATA_O <= rdata_nxt;
      end
    end
  end

  // Oscillator base tick, one per fastest period
  // Runs free, standby only clears the divider
  assign base_tick = (base_cnt_r == 32'(BASE_TICK_CYCLES - 1));

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || base_tick) begin
      base_cnt_r <= 32'h0000_0000;
    end else begin
      base_cnt_r <= base_cnt_r + 32'h0000_0001;
    end
  end

  always_comb begin
    if (rate_r[3:0] > RATE_CODE_FASTEST) begin
      rate_code = RATE_CODE_FASTEST;
    end else begin
      rate_code = rate_r[3:0];
    end
  end

  // divide by 2^(10-code), reserved codes run fastest
  assign div_last     = 11'((12'h001 << (RATE_CODE_FASTEST - rate_code)) - 12'h001);
  assign interval_due = base_tick && (div_cnt_r >= div_last);

  // Standby restarts the interval count
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || standby || interval_due) begin
      div_cnt_r <= 11'h000;
    end else if (base_tick) begin
      div_cnt_r <= div_cnt_r + 11'h001;
    end
  end

  // Conversion scheduler
  // standby halts conversions
  always_comb begin
    case (state_r)
      ST_STANDBY: begin
        if (standby) begin
          state_nxt = ST_STANDBY;
        end else begin
          state_nxt = ST_CONVERT;
        end
      end
      ST_WAIT: begin
        if (standby) begin
          state_nxt = ST_STANDBY;
        end else if (interval_due) begin
          state_nxt = ST_CONVERT;
        end else begin
          state_nxt = ST_WAIT;
        end
      end
      // Finish a running conversion even when standby is requested
      ST_CONVERT: begin
        if (!CONV_DONE_I) begin
          state_nxt = ST_CONVERT;
        end else if (standby) begin
          state_nxt = ST_STANDBY;
        end else begin
          state_nxt = ST_WAIT;
        end
      end
      default: state_nxt = ST_STANDBY;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_r      <= ST_STANDBY;
      CONV_START_O <= 1'b0;
      CONV_BUSY_O  <= 1'b0;
      range_conv_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      CONV_START_O <= (state_r != ST_CONVERT) && (state_nxt == ST_CONVERT);
      CONV_BUSY_O  <= (state_nxt == ST_CONVERT);
      if ((state_r != ST_CONVERT) && (state_nxt == ST_CONVERT)) begin
        range_conv_r <= config_r[CFG_RANGE_BIT];
      end
    end
  end

  assign local_enc  = 8'(clamp(CONV_RESULT_I.local_deg
                               + (range_conv_r ? EXT_OFFSET_DEG : 12'sh000),
                               range_conv_r ? EXT_MAX_DEG : BIN_MAX_DEG));
  assign remote_enc = 10'(clamp(CONV_RESULT_I.remote_qtr
                                + (range_conv_r ? EXT_OFFSET_QTR : 12'sh000),
                                range_conv_r ? EXT_MAX_QTR : BIN_MAX_QTR));

  // Done outside a conversion is dropped
  // converter-only update
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      local_res_r <= RST_RESULT;
      remote_hi_r <= RST_RESULT;
      remote_lo_r <= RST_RESULT;
    end else if (CONV_DONE_I && (state_r == ST_CONVERT)) begin
      local_res_r <= local_enc;
      remote_hi_r <= remote_enc[9:2];
      remote_lo_r <= {remote_enc[1:0], 6'h00};
    end
  end

  assign remote_val  = {remote_hi_r, remote_lo_r[7:6]};
  assign remote_high = {remote_high_hi_r, remote_high_lo_r[7:6]};
  assign remote_low  = {remote_low_hi_r, remote_low_lo_r[7:6]};

  // Per-channel limit logic, channel 0 local, channel 1 remote
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    logic [7:0] val_byte;
    logic [9:0] val_fine;
    logic [7:0] cut_lim;
    logic [7:0] high_byte;
    logic [9:0] high_fine;
    logic [9:0] low_fine;
    logic [8:0] cut_rel;
    logic [8:0] high_rel;
    logic       cut_r;
    logic       cut2_r;

    // Local byte widened to the remote quarter-degree format
    assign val_byte  = (ch == 0) ? local_res_r : remote_hi_r;
    assign val_fine  = (ch == 0) ? {local_res_r, 2'b00} : remote_val;
    assign cut_lim   = (ch == 0) ? local_cut_r : remote_cut_r;
    assign high_byte = (ch == 0) ? local_high_r : remote_high_hi_r;
    assign high_fine = (ch == 0) ? {local_high_r, 2'b00} : remote_high;
    assign low_fine  = (ch == 0) ? {local_low_r, 2'b00} : remote_low;
    assign cut_rel   = release_at(cut_lim, hyst_r);
    assign high_rel  = release_at(high_byte, hyst_r);

    assign alarm_vec[ch] = (val_fine > high_fine) || (val_fine <= low_fine);

    // Cutoff latches with hysteresis
    // release at limit minus hysteresis
    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        cut_r  <= 1'b0;
        cut2_r <= 1'b0;
      end else begin
        cut_r  <= (val_byte > cut_lim) || (cut_r && ({1'b0, val_byte} > cut_rel));
        cut2_r <= (val_fine > high_fine) || (cut2_r && ({1'b0, val_byte} > high_rel));
      end
    end

    assign cut_vec[ch]  = cut_r;
    assign cut2_vec[ch] = cut2_r;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      OVERTEMP_CUTOFF_OUT_N_O <= 1'b1;
      SHARED_PIN_N_O          <= 1'b1;
    end else begin
      OVERTEMP_CUTOFF_OUT_N_O <= !(|cut_vec);
      if (pin_is_cutoff) begin
        SHARED_PIN_N_O <= !(|cut2_vec);
      end else begin
        SHARED_PIN_N_O <= !((|alarm_vec) && !config_r[CFG_ALARM_MASK_BIT]);
      end
    end
  end

endmodule
